// [dv/ptc_pulse_src.sv]
// Pulse source model that drives the three capture inputs.
`timescale 1ns/10ps
module ptc_pulse_src (
  input  wire       pclk,
  input  wire       go,
  input  wire [1:0] chan,
  output reg  [2:0] pins
);
  integer n;
  initial pins = 3'h0;
  initial n = 0;
  // Each pulse is four cycles high, so both of its edges are seen.
  always @(posedge pclk) begin
    if (go) begin
      pins[chan] <= 1'b1;
      n <= 4;
    end else if (n == 1) begin
      pins <= 3'h0;
      n <= 0;
    end else if (n > 1) begin
      n <= n - 1;
    end
  end
endmodule

// [dv/ptc_timer_assertions.sv]
// Port-level assertions for the prescaled timer.
`timescale 1ns/10ps
`include "ptc_consts.vh"
module ptc_timer_assertions #(
  parameter CHANNELS = 3
) (
  input wire                  pclk,
  input wire                  presetn,
  input wire                  psel,
  input wire                  penable,
  input wire                  pwrite,
  input wire [11:0]           paddr,
  input wire [31:0]           pwdata,
  input wire [31:0]           prdata,
  input wire                  pready,
  input wire                  pslverr,
  input wire [CHANNELS-1:0]   capture_pin,
  input wire                  irq
);
  wire       acc = psel && penable;
  wire [9:0] ix  = paddr[11:2];
  wire       wr  = acc && pwrite;
  wire       rd  = acc && !pwrite;
  reg  [7:0] mode_reg;
  reg  [7:0] rcl_reg;
  reg  [7:0] rch_reg;
  reg  [7:0] cap_reg;
  reg  [7:0] ctl_reg;
  // Shadows of the software-only register bits.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= 8'h00;
      rcl_reg <= 8'h00;
      rch_reg <= 8'h00;
      cap_reg <= 8'h00;
      ctl_reg <= 8'h00;
    end else if (wr) begin
      if (ix == `PTC_IDX_MODE) mode_reg <= pwdata[7:0];
      if (ix == `PTC_IDX_RC_LOW) rcl_reg <= pwdata[7:0];
      if (ix == `PTC_IDX_RC_HIGH) rch_reg <= pwdata[7:0];
      if (ix == `PTC_IDX_CAP_CTRL) cap_reg <= pwdata[7:0];
      if (ix == `PTC_IDX_CONTROL) ctl_reg <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_xfer;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_mask_off;
    wr && ix == `PTC_IDX_IRQ_MASK && pwdata[3:0] == 4'h0;
  endsequence
  AST_READY: assert property (s_xfer |-> pready)
    else $error("pready missing in access phase");
  AST_IDLE: assert property (!penable |-> !pready && !pslverr)
    else $error("pready or pslverr outside access");
  AST_UNMAP: assert property (acc && ix == 10'h3FF |-> pslverr)
    else $error("unmapped access not refused");
  AST_HIGH: assert property (rd |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_MODE: assert property (rd && ix == `PTC_IDX_MODE |->
    prdata[7:0] == mode_reg) else $error("mode readback wrong");
  AST_RCL: assert property (rd && ix == `PTC_IDX_RC_LOW |->
    prdata[7:0] == rcl_reg) else $error("low reload readback wrong");
  AST_RCH: assert property (rd && ix == `PTC_IDX_RC_HIGH |->
    prdata[7:0] == rch_reg) else $error("high reload readback wrong");
  AST_CAPEN: assert property (rd && ix == `PTC_IDX_CAP_CTRL |->
    prdata[6:4] == cap_reg[6:4]) else $error("enable readback wrong");
  AST_CTRL: assert property (rd && ix == `PTC_IDX_CONTROL |->
    prdata[2] == ctl_reg[2] && prdata[0] == ctl_reg[0])
    else $error("control readback wrong");
  AST_IRQ_OFF: assert property (s_mask_off |=> !irq)
    else $error("irq high with all masked");
endmodule

bind ptc_timer ptc_timer_assertions #(.CHANNELS(CHANNELS)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
  .irq(irq)
);

// [dv/ptc_timer_tb.sv]
// Self-checking bench for the prescaled timer.
`timescale 1ns/10ps
`include "ptc_consts.vh"
module ptc_timer_tb;
  reg         pclk;
  reg         presetn;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire [2:0]  capture_pin;
  wire        irq;
  reg         go;
  reg  [1:0]  chan;
  reg  [31:0] rd;
  reg         er;
  integer     error_cnt;
  integer     checks;
  integer     cyc;
  integer     i;
  integer     n;
  ptc_timer #(.CHANNELS(3)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
    .irq(irq));
  ptc_pulse_src src_u (.pclk(pclk), .go(go), .chan(chan),
    .pins(capture_pin));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task check(input [31:0] s, input [31:0] e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED t=%0t seen %h want %h", $time, s, e);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks=%0d errors=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task bus(input w, input [9:0] ix, input [7:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {ix, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task wr(input [9:0] ix, input [7:0] d);
    bus(1'b1, ix, d);
  endtask
  task rdc(input [9:0] ix, input [31:0] e);
    begin
      bus(1'b0, ix, 8'h00);
      check(rd, e);
    end
  endtask
  task pulse(input [1:0] c);
    begin
      go <= 1'b1;
      chan <= c;
      @(posedge pclk);
      go <= 1'b0;
      repeat (12) @(posedge pclk);
    end
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    go = 1'b0;
    chan = 2'h0;
    error_cnt = 0;
    checks = 0;
    cyc = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`PTC_IDX_CAP_CTRL, 32'h00);
    rdc(`PTC_IDX_MODE, 32'h00);
    rdc(`PTC_IDX_RC_HIGH, 32'h00);
    rdc(`PTC_IDX_COUNT_LOW, 32'h00);
    rdc(`PTC_IDX_COUNT_HIGH, 32'h00);
    bus(1'b0, 10'h3FF, 8'h00);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    // Three ticks for each divider from 4 to 512, stopping midway between ticks.
    for (i = 1; i < 8; i = i + 1) begin
      n = (i == 1) ? 4 : (1 << (i + 2));
      wr(`PTC_IDX_MODE, {1'b0, i[2:0], 4'h0});
      wr(`PTC_IDX_COUNT_LOW, 8'h00);
      wr(`PTC_IDX_COUNT_HIGH, 8'h00);
      wr(`PTC_IDX_CONTROL, 8'h04);
      repeat (3 * n + n / 2 - 3) @(posedge pclk);
      wr(`PTC_IDX_CONTROL, 8'h00);
      rdc(`PTC_IDX_COUNT_LOW, 32'h3);
      repeat (40) @(posedge pclk);
      rdc(`PTC_IDX_COUNT_LOW, 32'h3);
    end
    wr(`PTC_IDX_RC_LOW, 8'h34);
    wr(`PTC_IDX_RC_HIGH, 8'h12);
    wr(`PTC_IDX_MODE, 8'h80);
    wr(`PTC_IDX_COUNT_LOW, 8'hFE);
    wr(`PTC_IDX_COUNT_HIGH, 8'hFF);
    wr(`PTC_IDX_CONTROL, 8'h04);
    repeat (4) @(posedge pclk);
    rdc(`PTC_IDX_CONTROL, 32'h84);
    wr(`PTC_IDX_CONTROL, 8'h80);
    bus(1'b0, `PTC_IDX_COUNT_LOW, 8'h00);
    check(rd, 32'h3C);
    rdc(`PTC_IDX_COUNT_HIGH, 32'h12);
    rdc(`PTC_IDX_IRQ_STATUS, 32'h1);
    check({31'h0, irq}, 32'h0);
    wr(`PTC_IDX_IRQ_MASK, 8'h01);
    check({31'h0, irq}, 32'h1);
    wr(`PTC_IDX_IRQ_STATUS, 8'h01);
    check({31'h0, irq}, 32'h0);
    wr(`PTC_IDX_CONTROL, 8'h01);
    wr(`PTC_IDX_MODE, 8'h04);
    wr(`PTC_IDX_COUNT_LOW, 8'h30);
    wr(`PTC_IDX_COUNT_HIGH, 8'h12);
    wr(`PTC_IDX_CONTROL, 8'h05);
    repeat (20) @(posedge pclk);
    rdc(`PTC_IDX_CONTROL, 32'h85);
    wr(`PTC_IDX_CONTROL, 8'h81);
    rdc(`PTC_IDX_COUNT_HIGH, 32'h00);
    rdc(`PTC_IDX_COUNT_LOW, 32'h16);
    wr(`PTC_IDX_CONTROL, 8'h00);
    wr(`PTC_IDX_CAP_CTRL, 8'h70);
    // A capture on another channel must not reload the counter.
    for (i = 0; i < 3; i = i + 1) begin
      wr(`PTC_IDX_COUNT_LOW, 8'h77);
      wr(`PTC_IDX_COUNT_HIGH, 8'h00);
      wr(`PTC_IDX_MODE, {6'h20, i[1:0] + 2'h1});
      pulse(2'((i + 1) % 3));
      rdc(`PTC_IDX_COUNT_LOW, 32'h77);
      pulse(i[1:0]);
      rdc(`PTC_IDX_COUNT_LOW, 32'h34);
      rdc(`PTC_IDX_COUNT_HIGH, 32'h12);
      rdc(10'(`PTC_IDX_CAP0_LOW + 2 * i), 32'h77);
    end
    rdc(`PTC_IDX_CAP_CTRL, 32'h77);
    wr(`PTC_IDX_CAP_CTRL, 8'h10);
    rdc(`PTC_IDX_CAP_CTRL, 32'h10);
    wr(`PTC_IDX_MODE, 8'h08);
    wr(`PTC_IDX_COUNT_LOW, 8'h55);
    pulse(2'h1);
    rdc(`PTC_IDX_CAP_CTRL, 32'h10);
    pulse(2'h0);
    rdc(`PTC_IDX_COUNT_LOW, 32'h00);
    rdc(`PTC_IDX_CAP0_LOW, 32'h55);
    rdc(`PTC_IDX_CAP_CTRL, 32'h11);
    wr(`PTC_IDX_IRQ_MASK, 8'h0F);
    check({31'h0, irq}, 32'h1);
    rdc(`PTC_IDX_IRQ_STATUS, 32'h2);
    wr(`PTC_IDX_IRQ_MASK, 8'h00);
    check({31'h0, irq}, 32'h0);
    // Edge select: none ignores the pulse, any captures both of its edges.
    wr(`PTC_IDX_CAP_CTRL, 8'h10);
    wr(`PTC_IDX_EDGE_SEL, 8'h03);
    pulse(2'h0);
    rdc(`PTC_IDX_CAP_CTRL, 32'h10);
    wr(`PTC_IDX_EDGE_SEL, 8'h02);
    wr(`PTC_IDX_CONTROL, 8'h04);
    pulse(2'h0);
    wr(`PTC_IDX_CONTROL, 8'h00);
    rdc(`PTC_IDX_CAP0_LOW, 32'h03);
    rdc(`PTC_IDX_CAP0_HIGH, 32'h00);
    rdc(`PTC_IDX_CAP_CTRL, 32'h11);
    close_out;
  end
endmodule

// [rtl/ptc_capture_chan.v]
// Synchroniser and edge detector for one capture input.
`timescale 1ns/10ps
module ptc_capture_chan (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       cap_pin,
  input  wire [1:0] edge_sel,
  input  wire       enable,
  output wire       edge_pulse
);
`include "ptc_consts.vh"

  reg  sync1_reg;
  reg  sync2_reg;
  reg  prev_reg;
  wire rise;
  wire fall;
  reg  hit;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= cap_pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  always @* begin
    case (edge_sel)
      `PTC_EDGE_FALL: hit = fall;
      `PTC_EDGE_RISE: hit = rise;
      `PTC_EDGE_ANY:  hit = rise | fall;
      default:        hit = 1'b0;
    endcase
  end

  assign edge_pulse = enable & hit; // [RULE10]
endmodule

// [rtl/ptc_consts.vh]
// Register indexes, field positions, reset values and counts of the timer.
`ifndef PTC_CONSTS_VH
`define PTC_CONSTS_VH

`define PTC_ADDR_W          12
`define PTC_IDX_W           10
`define PTC_DATA_W          32

`define PTC_IDX_CAP_CTRL    10'h092
`define PTC_IDX_EDGE_SEL    10'h093
`define PTC_IDX_CONTROL     10'h0C8
`define PTC_IDX_MODE        10'h0C9
`define PTC_IDX_RC_LOW      10'h0CA
`define PTC_IDX_RC_HIGH     10'h0CB
`define PTC_IDX_COUNT_LOW   10'h0CC
`define PTC_IDX_COUNT_HIGH  10'h0CD
`define PTC_IDX_CAP0_LOW    10'h0E0
`define PTC_IDX_CAP0_HIGH   10'h0E1
`define PTC_IDX_CAP1_LOW    10'h0E2
`define PTC_IDX_CAP1_HIGH   10'h0E3
`define PTC_IDX_CAP2_LOW    10'h0E4
`define PTC_IDX_CAP2_HIGH   10'h0E5
`define PTC_IDX_IRQ_STATUS  10'h0F8
`define PTC_IDX_IRQ_MASK    10'h0F9

`define PTC_MODE_RELOAD_EN  7
`define PTC_MODE_DIV_HI     6
`define PTC_MODE_DIV_LO     4
`define PTC_MODE_CAP_CLR    3
`define PTC_MODE_MATCH_CLR  2
`define PTC_MODE_TRIG_HI    1
`define PTC_MODE_TRIG_LO    0

`define PTC_CTRL_EVENT      7
`define PTC_CTRL_RUN        2
`define PTC_CTRL_CMP_MODE   0

`define PTC_CAP_EN_LO       4
`define PTC_CAP_EN_HI       6
`define PTC_CAP_FLAG_LO     0
`define PTC_CAP_FLAG_HI     2

`define PTC_TRIG_OVERFLOW   2'h0
`define PTC_EDGE_FALL       2'h0
`define PTC_EDGE_RISE       2'h1
`define PTC_EDGE_ANY        2'h2

`define PTC_RESET_BYTE      8'h00
`define PTC_COUNT_CLEAR     16'h0000
`define PTC_COUNT_MAX       16'hFFFF

`define PTC_DIV_MASK_1      9'h000
`define PTC_DIV_MASK_4      9'h003
`define PTC_DIV_MASK_16     9'h00F
`define PTC_DIV_MASK_32     9'h01F
`define PTC_DIV_MASK_64     9'h03F
`define PTC_DIV_MASK_128    9'h07F
`define PTC_DIV_MASK_256    9'h0FF
`define PTC_DIV_MASK_512    9'h1FF

`endif

// [rtl/ptc_prescaler.v]
// Clock divider that gives the counter its tick.
`timescale 1ns/10ps
module ptc_prescaler (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       run,
  input  wire [2:0] prescale_select,
  output wire       tick
);
`include "ptc_consts.vh"

  reg  [8:0] div_cnt_reg;
  wire [8:0] div_mask;

  function [8:0] div_mask_of;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    div_mask_of = `PTC_DIV_MASK_1;
        3'h1:    div_mask_of = `PTC_DIV_MASK_4;
        3'h2:    div_mask_of = `PTC_DIV_MASK_16;
        3'h3:    div_mask_of = `PTC_DIV_MASK_32;
        3'h4:    div_mask_of = `PTC_DIV_MASK_64;
        3'h5:    div_mask_of = `PTC_DIV_MASK_128;
        3'h6:    div_mask_of = `PTC_DIV_MASK_256;
        default: div_mask_of = `PTC_DIV_MASK_512;
      endcase
    end
  endfunction

  assign div_mask = div_mask_of(prescale_select);
  assign tick     = run && ((div_cnt_reg & div_mask) == div_mask); // [RULE2]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 9'h000;
    end else if (!run) begin
      div_cnt_reg <= 9'h000;
    end else begin
      div_cnt_reg <= div_cnt_reg + 9'h001;
    end
  end
endmodule

// [rtl/ptc_timer.v]
// Prescaled 16-bit timer with reload, compare and three capture channels.
// Operation
// [RULE1] With reload enabled, copy reload pair into counter on selected trigger.
// [RULE2] Prescale select picks divide by 1,4,16,32,64,128,256 or 512.
// [RULE3] Reload mode with capture clear set: capture event clears counter.
// [RULE4] Compare mode with match clear set: match clears counter.
// [RULE5] Trigger select: overflow, or capture channel 0, 1 or 2.
// [RULE6] Low reload/compare byte feeds low byte of compare or reload.
// [RULE7] High reload/compare byte feeds high byte of compare or reload.
// [RULE8] Counter is two separately readable and writable bytes.
// [RULE9] Software should stop the counter before touching its bytes.
// [RULE10] Each capture channel has its own enable bit, 6, 5, 4.
// [RULE11] Capture flag set on selected edge; only software clears it.
// [RULE12] Mode bit: zero is auto-reload, one is compare.
// [RULE13] Event flag set on overflow or match; only software clears it.
// [RULE14] Run bit low halts counter and keeps count; high counts.
// [RULE15] Capture edge copies counter into that channel's result pair.
// [RULE16] Counter steps on each tick, wraps at top, match on equality.
`timescale 1ns/10ps
`include "ptc_consts.vh"
module ptc_timer #(
  parameter CHANNELS = 3
) (
  input  wire                    pclk,
  input  wire                    presetn,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`PTC_ADDR_W-1:0]  paddr,
  input  wire [`PTC_DATA_W-1:0]  pwdata,
  output wire [`PTC_DATA_W-1:0]  prdata,
  output wire                    pready,
  output wire                    pslverr,
  input  wire [CHANNELS-1:0]     capture_pin,
  output wire                    irq
);

  reg  [7:0]              timer_two_mode_reg;
  reg  [7:0]              reload_compare_low_reg;
  reg  [7:0]              reload_compare_high_reg;
  reg  [15:0]             count_reg;
  reg  [15:0]             count_next;
  reg  [CHANNELS-1:0]     cap_enable_reg;
  reg  [CHANNELS-1:0]     cap_flag_reg;
  reg  [CHANNELS-1:0]     cap_flag_next;
  reg  [2*CHANNELS-1:0]   edge_sel_reg;
  reg                     counter_run_reg;
  reg                     compare_mode_reg;
  reg                     event_flag_reg;
  reg                     event_flag_next;
  reg  [3:0]              irq_mask_reg;
  reg  [15:0]             cap_result_reg [0:CHANNELS-1];
  reg  [`PTC_DATA_W-1:0]  prdata_reg;
  reg                     pslverr_reg;
  reg  [7:0]              rd_byte;
  reg                     rd_hit;
  reg                     event_set;
  reg                     reload_trig;
  integer                 i;

  wire [CHANNELS-1:0]     cap_edge;
  wire                    tick;
  wire [`PTC_IDX_W-1:0]   idx;
  wire                    wr_en;
  wire [7:0]              wbyte;
  wire                    reload_en;
  wire [2:0]              prescale_select;
  wire                    capture_auto_clear;
  wire                    match_auto_clear;
  wire [1:0]              reload_trigger_select;
  wire [15:0]             rc_value;
  wire [15:0]             count_inc;
  wire                    overflow;
  wire [3:0]              irq_status;
  wire                    wr_cap_ctrl;
  wire                    wr_edge_sel;
  wire                    wr_control;
  wire                    wr_mode;
  wire                    wr_rc_low;
  wire                    wr_rc_high;
  wire                    wr_count_low;
  wire                    wr_count_high;
  wire                    wr_irq_status;
  wire                    wr_irq_mask;

  function sel_is;
    input [`PTC_IDX_W-1:0] a;
    input [`PTC_IDX_W-1:0] b;
    begin
      sel_is = (a == b);
    end
  endfunction

  assign idx     = paddr[`PTC_ADDR_W-1:2];
  assign wr_en   = psel & penable & pwrite;
  assign wbyte   = pwdata[7:0];
  assign pready  = psel & penable;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg & psel & penable;

  assign wr_cap_ctrl   = wr_en & sel_is(idx, `PTC_IDX_CAP_CTRL);
  assign wr_edge_sel   = wr_en & sel_is(idx, `PTC_IDX_EDGE_SEL);
  assign wr_control    = wr_en & sel_is(idx, `PTC_IDX_CONTROL);
  assign wr_mode       = wr_en & sel_is(idx, `PTC_IDX_MODE);
  assign wr_rc_low     = wr_en & sel_is(idx, `PTC_IDX_RC_LOW);
  assign wr_rc_high    = wr_en & sel_is(idx, `PTC_IDX_RC_HIGH);
  assign wr_count_low  = wr_en & sel_is(idx, `PTC_IDX_COUNT_LOW);
  assign wr_count_high = wr_en & sel_is(idx, `PTC_IDX_COUNT_HIGH);
  assign wr_irq_status = wr_en & sel_is(idx, `PTC_IDX_IRQ_STATUS);
  assign wr_irq_mask   = wr_en & sel_is(idx, `PTC_IDX_IRQ_MASK);

  assign reload_en             = timer_two_mode_reg[`PTC_MODE_RELOAD_EN];
  assign prescale_select       =
    timer_two_mode_reg[`PTC_MODE_DIV_HI:`PTC_MODE_DIV_LO];
  assign capture_auto_clear    = timer_two_mode_reg[`PTC_MODE_CAP_CLR];
  assign match_auto_clear      = timer_two_mode_reg[`PTC_MODE_MATCH_CLR];
  assign reload_trigger_select =
    timer_two_mode_reg[`PTC_MODE_TRIG_HI:`PTC_MODE_TRIG_LO];

  assign rc_value  = {reload_compare_high_reg, // [RULE7]
                      reload_compare_low_reg}; // [RULE6]
  assign count_inc = count_reg + 16'h0001;
  assign overflow  = tick && (count_reg == `PTC_COUNT_MAX); // [RULE16]

  ptc_prescaler u_prescaler (
    .pclk            (pclk),
    .presetn         (presetn),
    .run             (counter_run_reg),
    .prescale_select (prescale_select),
    .tick            (tick)
  );

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : gen_cap
      ptc_capture_chan u_chan (
        .pclk       (pclk),
        .presetn    (presetn),
        .cap_pin    (capture_pin[g]),
        .edge_sel   (edge_sel_reg[2*g+1:2*g]),
        .enable     (cap_enable_reg[g]),
        .edge_pulse (cap_edge[g])
      );
    end
  endgenerate

  // Reload trigger multiplexer.
  always @* begin
    case (reload_trigger_select) // [RULE5]
      `PTC_TRIG_OVERFLOW: reload_trig = overflow;
      2'h1:               reload_trig = cap_edge[0];
      2'h2:               reload_trig = cap_edge[1];
      default:            reload_trig = cap_edge[2];
    endcase
  end

  // Next count: tick, match, capture clear, reload, then software bytes.
  always @* begin
    count_next = count_reg;
    event_set  = 1'b0;
    if (tick) begin
      count_next = count_inc; // [RULE14] [RULE16]
      if (overflow) begin
        event_set = 1'b1; // [RULE13]
      end
      if (compare_mode_reg && (count_inc == rc_value)) begin
        event_set = 1'b1; // [RULE13] [RULE16]
        if (match_auto_clear) begin
          count_next = `PTC_COUNT_CLEAR; // [RULE4]
        end
      end
    end
    if (!compare_mode_reg) begin // [RULE12]
      if ((|cap_edge) && capture_auto_clear) begin
        count_next = `PTC_COUNT_CLEAR; // [RULE3]
      end else if (reload_en && reload_trig) begin
        count_next = rc_value; // [RULE1]
      end
    end
    if (wr_count_low) begin
      count_next[7:0] = wbyte; // [RULE8]
    end
    if (wr_count_high) begin
      count_next[15:8] = wbyte; // [RULE8]
    end
  end

  // Flags: a hardware set in the same cycle as a clear wins.
  always @* begin
    event_flag_next = event_flag_reg;
    cap_flag_next   = cap_flag_reg;
    if (wr_control) begin
      event_flag_next = wbyte[`PTC_CTRL_EVENT];
    end
    if (wr_cap_ctrl) begin
      cap_flag_next = wbyte[`PTC_CAP_FLAG_HI:`PTC_CAP_FLAG_LO];
    end
    if (wr_irq_status) begin
      event_flag_next = event_flag_reg & ~wbyte[0];
      cap_flag_next   = cap_flag_reg & ~wbyte[CHANNELS:1];
    end
    event_flag_next = event_flag_next | event_set; // [RULE13]
    cap_flag_next   = cap_flag_next | cap_edge; // [RULE11]
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg      <= `PTC_COUNT_CLEAR;
      event_flag_reg <= 1'b0;
      cap_flag_reg   <= {CHANNELS{1'b0}};
    end else begin
      count_reg      <= count_next;
      event_flag_reg <= event_flag_next;
      cap_flag_reg   <= cap_flag_next;
    end
  end

  // Capture results.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        cap_result_reg[i] <= `PTC_COUNT_CLEAR;
      end
    end else begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        if (cap_edge[i]) begin
          cap_result_reg[i] <= count_reg; // [RULE15]
        end
      end
    end
  end

  // Software written control registers.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_two_mode_reg      <= `PTC_RESET_BYTE;
      reload_compare_low_reg  <= `PTC_RESET_BYTE;
      reload_compare_high_reg <= `PTC_RESET_BYTE;
      cap_enable_reg          <= {CHANNELS{1'b0}};
      edge_sel_reg            <= {2*CHANNELS{1'b0}};
      counter_run_reg         <= 1'b0;
      compare_mode_reg        <= 1'b0;
      irq_mask_reg            <= 4'h0;
    end else begin
      if (wr_mode) begin
        timer_two_mode_reg <= wbyte;
      end
      if (wr_rc_low) begin
        reload_compare_low_reg <= wbyte;
      end
      if (wr_rc_high) begin
        reload_compare_high_reg <= wbyte;
      end
      if (wr_cap_ctrl) begin
        cap_enable_reg <= wbyte[`PTC_CAP_EN_HI:`PTC_CAP_EN_LO]; // [RULE10]
      end
      if (wr_edge_sel) begin
        edge_sel_reg <= wbyte[2*CHANNELS-1:0];
      end
      if (wr_control) begin
        counter_run_reg  <= wbyte[`PTC_CTRL_RUN]; // [RULE14]
        compare_mode_reg <= wbyte[`PTC_CTRL_CMP_MODE]; // [RULE12]
      end
      if (wr_irq_mask) begin
        irq_mask_reg <= wbyte[3:0];
      end
    end
  end

  assign irq_status = {cap_flag_reg, event_flag_reg};
  assign irq        = |(irq_status & irq_mask_reg);

  // Read multiplexer.
  always @* begin
    rd_byte = `PTC_RESET_BYTE;
    rd_hit  = 1'b1;
    case (idx)
      `PTC_IDX_CAP_CTRL: begin
        rd_byte = {1'b0, cap_enable_reg, 1'b0, cap_flag_reg};
      end
      `PTC_IDX_EDGE_SEL: begin
        rd_byte = {2'h0, edge_sel_reg};
      end
      `PTC_IDX_CONTROL: begin
        rd_byte = {event_flag_reg, 4'h0, counter_run_reg, 1'b0,
                   compare_mode_reg};
      end
      `PTC_IDX_MODE: begin
        rd_byte = timer_two_mode_reg;
      end
      `PTC_IDX_RC_LOW: begin
        rd_byte = reload_compare_low_reg;
      end
      `PTC_IDX_RC_HIGH: begin
        rd_byte = reload_compare_high_reg;
      end
      `PTC_IDX_COUNT_LOW: begin
        rd_byte = count_reg[7:0]; // [RULE8]
      end
      `PTC_IDX_COUNT_HIGH: begin
        rd_byte = count_reg[15:8]; // [RULE8]
      end
      `PTC_IDX_CAP0_LOW: begin
        rd_byte = cap_result_reg[0][7:0];
      end
      `PTC_IDX_CAP0_HIGH: begin
        rd_byte = cap_result_reg[0][15:8];
      end
      `PTC_IDX_CAP1_LOW: begin
        rd_byte = cap_result_reg[1][7:0];
      end
      `PTC_IDX_CAP1_HIGH: begin
        rd_byte = cap_result_reg[1][15:8];
      end
      `PTC_IDX_CAP2_LOW: begin
        rd_byte = cap_result_reg[2][7:0];
      end
      `PTC_IDX_CAP2_HIGH: begin
        rd_byte = cap_result_reg[2][15:8];
      end
      `PTC_IDX_IRQ_STATUS: begin
        rd_byte = {4'h0, irq_status};
      end
      `PTC_IDX_IRQ_MASK: begin
        rd_byte = {4'h0, irq_mask_reg};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read data and error are captured in the setup cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= {`PTC_DATA_W{1'b0}};
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      prdata_reg  <= pwrite ? {`PTC_DATA_W{1'b0}} : {24'h000000, rd_byte};
      pslverr_reg <= !rd_hit;
    end
  end
endmodule
